// [hw/scp_pkg.sv]
package scp_pkg;
	// System clock period
	localparam int CLK_PERIOD_NS = 25;
	// Bits in one command or data byte
	localparam int BYTE_BITS = 8;
	// Fixed low part of the seven-bit bus address
	localparam logic [3:0] I2C_ADDR_LOW = 4'h5;
	// Read-back register value after reset
	localparam logic [7:0] RB_RESET = 8'h00;
	// Default command codes of the three read commands
	localparam logic [7:0] READ_STATUS_CMD_DEF = 8'h01;
	localparam logic [7:0] READ_ERROR_CMD_DEF = 8'h02;
	localparam logic [7:0] READ_VERSION_CMD_DEF = 8'h03;
	// Serial clock half period made by the host
	localparam int SCK_HALF_NS = 125;
	// Bus clock low time, whole bit time at 400 kbit/s, setup and free time
	localparam int I2C_LOW_NS = 1300;
	localparam int I2C_BIT_NS = 2500;
	localparam int I2C_SU_NS = 600;
	localparam int I2C_BUF_NS = 1300;

	// Least time to whole cycles, rounded up, at least one
	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Cycle counts derived from the times above
	localparam int SCK_HALF_CYC = ns2cyc(SCK_HALF_NS);
	localparam int I2C_LOW_CYC = ns2cyc(I2C_LOW_NS);
	localparam int I2C_HIGH_CYC = ns2cyc(I2C_BIT_NS) - I2C_LOW_CYC;
	localparam int I2C_SU_CYC = ns2cyc(I2C_SU_NS);
	localparam int I2C_BUF_CYC = ns2cyc(I2C_BUF_NS);

	// Device bus slave states, Gray along the usual path
	typedef enum logic [2:0] {
		SI_IDLE = 3'h0,
		SI_ADDR = 3'h1,
		SI_ACK_A = 3'h3,
		SI_WR = 3'h2,
		SI_ACK_W = 3'h6,
		SI_RD = 3'h7,
		SI_ACK_R = 3'h5
	} scp_slv_st_t;

	// Host sequencer states, Gray along the usual path
	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_SEL = 3'h1,
		HS_LO = 3'h3,
		HS_HI = 3'h2,
		HS_END = 3'h6,
		HS_STOP = 3'h7,
		HS_FREE = 3'h5
	} scp_host_st_t;
endpackage

// [hw/scp_if.sv]
`timescale 1ns/1ps
interface scp_if;
	// Clocked serial wires
	logic port_select_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	// Host pulls the bus clock low
	logic scl_m_oe;
	// Open-drain data: host enable, device level and enable
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	// Resolved levels, pull-ups assumed
	logic scl;
	logic sda;
	logic so_line;

	// Bus clock released means high
	assign scl = !scl_m_oe;
	// Any driver pulling low wins
	assign sda = !(sda_m_oe | (sda_s_oe & !sda_s_o));
	// Floating serial output reads as pulled high
	assign so_line = so_oe ? so : 1'h1;

	modport dev(
		input port_select_n, sck, si, scl, sda,
		output so, so_oe, sda_s_o, sda_s_oe
	);
	modport host(
		output port_select_n, sck, si, scl_m_oe, sda_m_oe,
		input so_line, sda
	);
endinterface

// [hw/scp_dev.sv]
`timescale 1ns/1ps
// Functional notes
// - Command bits shift in MSB first
// - Eighth active edge completes a byte
// - Clock high at select: rise in, fall out
// - Clock low at select: fall in, rise out
// - Select tied low uses rise in, fall out
// - Select high resets the serial front end
// - Output floats whenever select is high
// - Read shifts read-back bits on output edge
// - Bus slave works at fast mode rates
// - Address upper three bits from strap pins
// - Eighth address bit gives transfer direction
// - Whole bytes, each one acknowledged
// - Writes carry one to three command bytes
// - Status read: command, stop, then read
// - Address low four bits fixed 0101
// - Read-back refreshed only by read commands
module scp_dev
	import scp_pkg::*;
#(
	parameter logic [7:0] READ_STATUS_CMD = READ_STATUS_CMD_DEF,
	parameter logic [7:0] READ_ERROR_CMD = READ_ERROR_CMD_DEF,
	parameter logic [7:0] READ_VERSION_CMD = READ_VERSION_CMD_DEF
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	scp_if.dev LINK,
	input wire logic ADDR_STRAP_BIT0_I,
	input wire logic ADDR_STRAP_BIT1_I,
	input wire logic ADDR_STRAP_BIT2_I,
	input wire logic [7:0] STATUS_I,
	input wire logic [7:0] ERROR_I,
	input wire logic [7:0] VERSION_I,
	output logic [7:0] CMD_BYTE_O,
	output logic CMD_VALID_O,
	output logic CMD_FIRST_O,
	output logic CMD_I2C_O
);
	// ---------------- Serial link domain ----------------
	logic mode_fall_q; // Sample on falling serial clock
	logic sck_int; // Serial clock turned so sampling is its rising edge
	logic ser_rst; // Front end reset while deselected
	logic [2:0] bit_cnt_q; // Bits taken in this byte
	logic [6:0] shift_q; // Partial byte
	logic seen_q; // A byte already done in this select
	logic [7:0] ser_byte_q; // Last whole serial byte
	logic ser_first_q; // That byte was first of its select
	logic ser_tog_q; // Flips once per whole byte
	logic [2:0] out_idx_q; // Output bit position
	logic so_q; // Serial output level
	logic so_oe_q; // Serial output driven
	// ---------------- System domain ----------------
	logic [2:0] ser_sync_q; // Toggle synchroniser and edge stage
	logic [1:0] scl_sync_q; // Bus clock synchroniser
	logic [1:0] sda_sync_q; // Bus data synchroniser
	logic scl_p_q; // Bus clock one cycle older
	logic sda_p_q; // Bus data one cycle older
	logic [2:0] strap_s1_q; // Strap first stage
	logic [2:0] strap_q; // Strap second stage
	logic [7:0] rb_q; // Read-back register
	scp_slv_st_t st_q; // Bus slave state
	logic [3:0] cnt_q; // Bus bits in this byte
	logic [7:0] rsh_q; // Bus receive shift
	logic [7:0] tsh_q; // Bus transmit shift
	logic first_q; // Next written byte is the first
	logic nack_q; // Master refused more data
	logic sda_oe_q; // Bus data pulled low
	logic sda_o_q; // Bus data level when driven
	logic i2c_ev_q; // Bus byte ready pulse
	logic [7:0] i2c_byte_q; // Bus byte
	logic i2c_first_q; // Bus byte was first after address
	logic ser_ev; // Serial byte arrived
	logic scl_rise; // Bus clock edges and conditions
	logic scl_fall;
	logic start_c;
	logic stop_c;

	// Pick sampling edge when select falls; reset leaves rising edge
	always_ff @(negedge LINK.port_select_n or posedge RESET_I) begin
		if (RESET_I) begin
			mode_fall_q <= 1'h0;
		end else begin
			mode_fall_q <= !LINK.sck;
		end
	end

	// Inverted clock when sampling on falling edge
	assign sck_int = LINK.sck ^ mode_fall_q;
	assign ser_rst = RESET_I | LINK.port_select_n;

	// Sample input bits, MSB first, count wraps every byte
	always_ff @(posedge sck_int or posedge ser_rst) begin
		if (ser_rst) begin
			bit_cnt_q <= 3'h0;
			shift_q <= 7'h00;
			seen_q <= 1'h0;
		end else begin
			shift_q <= {shift_q[5:0], LINK.si};
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (bit_cnt_q == 3'h7) begin
				seen_q <= 1'h1;
			end
		end
	end

	// Hold each finished byte until the system side takes it
	always_ff @(posedge sck_int or posedge RESET_I) begin
		if (RESET_I) begin
			ser_byte_q <= 8'h00;
			ser_first_q <= 1'h0;
			ser_tog_q <= 1'h0;
		end else if (LINK.port_select_n == 1'h0 && bit_cnt_q == 3'h7) begin
			// Eighth active edge closes the byte
			ser_byte_q <= {shift_q, LINK.si};
			ser_first_q <= !seen_q;
			ser_tog_q <= !ser_tog_q;
		end
	end

	// Shift read-back out on the opposite edge; float while deselected.
	// Read-back only changes after a command byte, so it is quiet here.
	always_ff @(negedge sck_int or posedge ser_rst) begin
		if (ser_rst) begin
			out_idx_q <= 3'h0;
			so_q <= 1'h0;
			so_oe_q <= 1'h0;
		end else begin
			so_q <= rb_q[3'h7 - out_idx_q];
			out_idx_q <= out_idx_q + 3'h1;
			so_oe_q <= 1'h1;
		end
	end

	assign LINK.so = so_q;
	assign LINK.so_oe = so_oe_q;
	assign LINK.sda_s_o = sda_o_q;
	assign LINK.sda_s_oe = sda_oe_q;

	// Bring serial byte toggle and bus pins into the system clock
	// Bus oversampled at 40 MHz, ample for fast mode
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ser_sync_q <= 3'h0;
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_p_q <= 1'h1;
			sda_p_q <= 1'h1;
			strap_s1_q <= 3'h0;
			strap_q <= 3'h0;
		end else begin
			ser_sync_q <= {ser_sync_q[1:0], ser_tog_q};
			scl_sync_q <= {scl_sync_q[0], LINK.scl};
			sda_sync_q <= {sda_sync_q[0], LINK.sda};
			scl_p_q <= scl_sync_q[1];
			sda_p_q <= sda_sync_q[1];
			strap_s1_q <= {ADDR_STRAP_BIT2_I, ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT0_I};
			strap_q <= strap_s1_q;
		end
	end

	// Edges and bus conditions, all on second-stage values
	assign ser_ev = ser_sync_q[2] ^ ser_sync_q[1];
	assign scl_rise = scl_sync_q[1] & !scl_p_q;
	assign scl_fall = !scl_sync_q[1] & scl_p_q;
	assign start_c = scl_sync_q[1] & scl_p_q & sda_p_q & !sda_sync_q[1];
	assign stop_c = scl_sync_q[1] & scl_p_q & !sda_p_q & sda_sync_q[1];

	// Bus slave: address, direction, bytes and acknowledges
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			st_q <= SI_IDLE;
			cnt_q <= 4'h0;
			rsh_q <= 8'h00;
			tsh_q <= 8'h00;
			first_q <= 1'h0;
			nack_q <= 1'h0;
			sda_oe_q <= 1'h0;
			sda_o_q <= 1'h0;
			i2c_ev_q <= 1'h0;
			i2c_byte_q <= 8'h00;
			i2c_first_q <= 1'h0;
		end else begin
			i2c_ev_q <= 1'h0;
			if (start_c) begin
				// Start or repeated start: take the address next
				st_q <= SI_ADDR;
				cnt_q <= 4'h0;
				sda_oe_q <= 1'h0;
			end else if (stop_c) begin
				st_q <= SI_IDLE;
				sda_oe_q <= 1'h0;
			end else if (scl_rise) begin
				// Take a bit while the clock is high
				case (st_q)
					SI_ADDR, SI_WR: begin
						rsh_q <= {rsh_q[6:0], sda_sync_q[1]};
						cnt_q <= cnt_q + 4'h1;
					end
					SI_RD: begin
						cnt_q <= cnt_q + 4'h1;
					end
					SI_ACK_R: begin
						nack_q <= sda_sync_q[1];
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				// Change the line while the clock is low
				case (st_q)
					SI_ADDR: begin
						if (cnt_q == 4'h8 && rsh_q[7:1] == {strap_q, I2C_ADDR_LOW}) begin
							st_q <= SI_ACK_A;
							sda_oe_q <= 1'h1;
						end else if (cnt_q == 4'h8) begin
							st_q <= SI_IDLE;
						end
					end
					SI_ACK_A: begin
						cnt_q <= 4'h0;
						first_q <= 1'h1;
						if (rsh_q[0]) begin
							// Direction bit one: master reads
							st_q <= SI_RD;
							tsh_q <= rb_q;
							sda_oe_q <= !rb_q[7];
						end else begin
							st_q <= SI_WR;
							sda_oe_q <= 1'h0;
						end
					end
					SI_WR: begin
						if (cnt_q == 4'h8) begin
							// Acknowledge and hand the byte on
							st_q <= SI_ACK_W;
							sda_oe_q <= 1'h1;
							i2c_ev_q <= 1'h1;
							i2c_byte_q <= rsh_q;
							i2c_first_q <= first_q;
							first_q <= 1'h0;
						end
					end
					SI_ACK_W: begin
						st_q <= SI_WR;
						cnt_q <= 4'h0;
						sda_oe_q <= 1'h0;
					end
					SI_RD: begin
						if (cnt_q == 4'h8) begin
							// Release for the master's acknowledge
							st_q <= SI_ACK_R;
							sda_oe_q <= 1'h0;
						end else begin
							tsh_q <= {tsh_q[6:0], 1'h0};
							sda_oe_q <= !tsh_q[6];
						end
					end
					SI_ACK_R: begin
						cnt_q <= 4'h0;
						if (nack_q) begin
							st_q <= SI_IDLE;
							sda_oe_q <= 1'h0;
						end else begin
							// Master wants more: repeat read-back
							st_q <= SI_RD;
							tsh_q <= rb_q;
							sda_oe_q <= !rb_q[7];
						end
					end
					default: begin
						sda_oe_q <= 1'h0;
					end
				endcase
			end
		end
	end

	// Hand command bytes to the user; serial wins a same-cycle clash
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			CMD_BYTE_O <= 8'h00;
			CMD_VALID_O <= 1'h0;
			CMD_FIRST_O <= 1'h0;
			CMD_I2C_O <= 1'h0;
		end else if (ser_ev) begin
			CMD_BYTE_O <= ser_byte_q;
			CMD_VALID_O <= 1'h1;
			CMD_FIRST_O <= ser_first_q;
			CMD_I2C_O <= 1'h0;
		end else if (i2c_ev_q) begin
			CMD_BYTE_O <= i2c_byte_q;
			CMD_VALID_O <= 1'h1;
			CMD_FIRST_O <= i2c_first_q;
			CMD_I2C_O <= 1'h1;
		end else begin
			CMD_VALID_O <= 1'h0;
		end
	end

	// Refresh read-back only on a read command as the first byte
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			rb_q <= RB_RESET;
		end else if (CMD_VALID_O && CMD_FIRST_O) begin
			case (CMD_BYTE_O)
				READ_STATUS_CMD: rb_q <= STATUS_I;
				READ_ERROR_CMD: rb_q <= ERROR_I;
				READ_VERSION_CMD: rb_q <= VERSION_I;
				default: begin
				end
			endcase
		end
	end
endmodule

// [hw/scp_host.sv]
`timescale 1ns/1ps
module scp_host
	import scp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	scp_if.host LINK,
	input wire logic REQ_I,
	input wire logic REQ_I2C_I,
	input wire logic REQ_READ_I,
	input wire logic [1:0] REQ_LEN_I,
	input wire logic [23:0] REQ_DATA_I,
	input wire logic [2:0] TARGET_STRAP_I,
	output logic BUSY_O,
	output logic DONE_O,
	output logic NACK_O,
	output logic [7:0] RDATA_O
);
	scp_host_st_t st_q; // Sequencer state
	logic [7:0] tmr_q; // Wait counter
	logic [31:0] tx_q; // Bytes to send, MSB first
	logic [2:0] nbytes_q; // Bytes left including current
	logic [3:0] bit_q; // Bit in current byte
	logic i2c_q; // Transfer uses the bus
	logic rd_q; // Transfer reads
	logic first_q; // Current byte is the first
	logic [7:0] rx_q; // Received bits
	logic cs_n_q, sck_q, si_q, scl_oe_q, sda_oe_q; // Pin drivers
	logic [1:0] so_sync_q; // Serial input synchroniser
	logic [1:0] sda_sync_q; // Bus data synchroniser
	logic ack_slot; // Ninth bit of a bus byte
	logic rd_byte; // Bus byte sent by the device
	logic bit_val; // Level to put on the line
	logic nack_now; // Device refused a byte
	logic last_bit; // Last bit of current byte
	logic nxt_ack; // Next bit is an acknowledge slot
	logic nxt_rd; // Next bit belongs to a byte the device sends
	logic nxt_val; // Level for the next bit

	// Clock low time for this transfer type
	function automatic logic [7:0] lo_cyc(input logic i2c);
		return i2c ? 8'(I2C_LOW_CYC) : 8'(SCK_HALF_CYC);
	endfunction

	// Clock high time for this transfer type
	function automatic logic [7:0] hi_cyc(input logic i2c);
		return i2c ? 8'(I2C_HIGH_CYC) : 8'(SCK_HALF_CYC);
	endfunction

	assign ack_slot = i2c_q && bit_q == 4'h8;
	assign rd_byte = i2c_q && rd_q && !first_q;
	assign bit_val = (ack_slot | rd_byte) ? 1'h1 : tx_q[31];
	assign nack_now = ack_slot && !rd_byte && sda_sync_q[1];
	assign last_bit = bit_q == (i2c_q ? 4'h8 : 4'h7);
	// Next bit worked out ahead, so data moves with the clock fall
	assign nxt_ack = i2c_q && bit_q == 4'h7;
	assign nxt_rd = i2c_q && rd_q && (!first_q || last_bit);
	assign nxt_val = (nxt_ack | nxt_rd) ? 1'h1 : (ack_slot ? tx_q[31] : tx_q[30]);

	assign LINK.port_select_n = cs_n_q;
	assign LINK.sck = sck_q;
	assign LINK.si = si_q;
	assign LINK.scl_m_oe = scl_oe_q;
	assign LINK.sda_m_oe = sda_oe_q;

	// Synchronise the lines the device drives
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			so_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
		end else begin
			so_sync_q <= {so_sync_q[0], LINK.so_line};
			sda_sync_q <= {sda_sync_q[0], LINK.sda};
		end
	end

	// Transfer sequencer: select or start, bits, deselect or stop
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			st_q <= HS_IDLE;
			tmr_q <= 8'h00;
			tx_q <= 32'h0;
			nbytes_q <= 3'h0;
			bit_q <= 4'h0;
			i2c_q <= 1'h0;
			rd_q <= 1'h0;
			first_q <= 1'h0;
			rx_q <= 8'h00;
			cs_n_q <= 1'h1;
			sck_q <= 1'h1;
			si_q <= 1'h0;
			scl_oe_q <= 1'h0;
			sda_oe_q <= 1'h0;
			BUSY_O <= 1'h0;
			DONE_O <= 1'h0;
			NACK_O <= 1'h0;
			RDATA_O <= 8'h00;
		end else begin
			DONE_O <= 1'h0;
			if (tmr_q != 8'h00) begin
				tmr_q <= tmr_q - 8'h01;
			end else begin
				case (st_q)
					HS_IDLE: begin
						if (REQ_I) begin
							// Serial clock idles high: device samples rising
							i2c_q <= REQ_I2C_I;
							rd_q <= REQ_READ_I;
							first_q <= 1'h1;
							bit_q <= 4'h0;
							NACK_O <= 1'h0;
							BUSY_O <= 1'h1;
							if (REQ_I2C_I) begin
								tx_q <= {TARGET_STRAP_I, I2C_ADDR_LOW, REQ_READ_I, REQ_DATA_I};
								nbytes_q <= REQ_READ_I ? 3'h2 : {1'h0, REQ_LEN_I} + 3'h1;
								sda_oe_q <= 1'h1;
								tmr_q <= 8'(I2C_SU_CYC);
							end else begin
								tx_q <= {REQ_DATA_I, 8'h00};
								nbytes_q <= REQ_READ_I ? 3'h1 : {1'h0, REQ_LEN_I};
								cs_n_q <= 1'h0;
								tmr_q <= 8'(SCK_HALF_CYC);
							end
							st_q <= HS_SEL;
						end
					end
					HS_SEL: begin
						// First clock fall, first bit out; serial clock still on the bus
						sck_q <= i2c_q;
						scl_oe_q <= i2c_q;
						si_q <= bit_val;
						sda_oe_q <= i2c_q & !bit_val;
						tmr_q <= lo_cyc(i2c_q);
						st_q <= HS_LO;
					end
					HS_LO: begin
						sck_q <= 1'h1;
						scl_oe_q <= 1'h0;
						tmr_q <= hi_cyc(i2c_q);
						st_q <= HS_HI;
					end
					HS_HI: begin
						// Sample, drop the clock, move on
						if (!ack_slot) begin
							rx_q <= {rx_q[6:0], i2c_q ? sda_sync_q[1] : so_sync_q[1]};
							tx_q <= {tx_q[30:0], 1'h0};
						end
						if (nack_now) begin
							NACK_O <= 1'h1;
						end
						sck_q <= i2c_q;
						scl_oe_q <= i2c_q;
						tmr_q <= lo_cyc(i2c_q);
						if (last_bit && (nbytes_q == 3'h1 || nack_now)) begin
							si_q <= 1'h0;
							sda_oe_q <= i2c_q;
							st_q <= HS_END;
						end else begin
							// Put the next bit on the line while the clock is low
							si_q <= nxt_val;
							sda_oe_q <= i2c_q & !nxt_val;
							if (last_bit) begin
								bit_q <= 4'h0;
								nbytes_q <= nbytes_q - 3'h1;
								first_q <= 1'h0;
							end else begin
								bit_q <= bit_q + 4'h1;
							end
							st_q <= HS_LO;
						end
					end
					HS_END: begin
						// Clock back to idle high
						sck_q <= 1'h1;
						scl_oe_q <= 1'h0;
						tmr_q <= i2c_q ? 8'(I2C_SU_CYC) : 8'(SCK_HALF_CYC);
						st_q <= HS_STOP;
					end
					HS_STOP: begin
						// Deselect or stop condition
						cs_n_q <= 1'h1;
						sda_oe_q <= 1'h0;
						RDATA_O <= rx_q;
						tmr_q <= 8'(I2C_BUF_CYC);
						st_q <= HS_FREE;
					end
					HS_FREE: begin
						BUSY_O <= 1'h0;
						DONE_O <= 1'h1;
						st_q <= HS_IDLE;
					end
					default: begin
						st_q <= HS_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// [testbench/scp_link_monitor.sv]
`timescale 1ns/1ps
module scp_link_monitor
	import scp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic port_select_n,
	input wire logic sck,
	input wire logic so,
	input wire logic so_oe,
	input wire logic sda_s_oe,
	input wire logic scl
);
	// Clock level seen while deselected, kept over the frame
	logic mode_q;
	// Samples of bus clock low in a row
	int low_cnt_q;

	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	// Catch the clock level up to the select fall
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			mode_q <= 1'h1;
		end else if (port_select_n) begin
			mode_q <= sck;
		end
	end

	// Count bus clock low samples
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			low_cnt_q <= 0;
		end else if (scl) begin
			low_cnt_q <= 0;
		end else begin
			low_cnt_q <= low_cnt_q + 1;
		end
	end

	a_so_float_desel: assert property (port_select_n |-> !so_oe)
		else $error("serial output driven while deselected");
	a_so_clear_desel: assert property (port_select_n && $past(port_select_n) |-> so == 1'h0)
		else $error("serial output not cleared by deselect");
	a_so_out_edge: assert property (!port_select_n && $changed(so) |-> $changed(sck) && sck != mode_q)
		else $error("serial output moved off its output edge");
	a_so_drive_start: assert property ($rose(so_oe) |-> $changed(sck) && sck != mode_q)
		else $error("serial output enabled off its output edge");
	a_ack_rise_low: assert property ($rose(sda_s_oe) |-> !scl && !$past(scl))
		else $error("device took data line while bus clock high");
	a_ack_fall_low: assert property ($fell(sda_s_oe) |-> !scl && !$past(scl))
		else $error("device released data line while bus clock high");
	// Low for the whole minimum shows as the full count; the check allows one sample less
	a_scl_low_time: assert property ($rose(scl) |-> low_cnt_q >= I2C_LOW_CYC - 1)
		else $error("bus clock low phase too short");
	a_sck_idle_desel: assert property (port_select_n && $past(port_select_n) |-> $stable(sck))
		else $error("serial clock moved outside a frame");
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
	import scp_pkg::*;
	// Clock, reset and stimulus
	logic clk, rst, req, req_i2c, req_read;
	logic [1:0] req_len;
	logic [23:0] req_data;
	logic [2:0] tgt_strap, dev_strap;
	logic [7:0] status, error, version;
	// Observed outputs
	logic busy, done, nack, cmd_valid, cmd_first, cmd_i2c;
	logic [7:0] rdata, cmd_byte;
	// Random state and tallies
	logic [31:0] seed;
	int fail_count, checked;
	// Delivered bytes as {i2c, first, byte}
	logic [9:0] got_q[$];

	scp_if link_if();
	scp_host scp_host_inst(.CLK_I(clk), .RESET_I(rst), .LINK(link_if.host), .REQ_I(req),
		.REQ_I2C_I(req_i2c), .REQ_READ_I(req_read), .REQ_LEN_I(req_len), .REQ_DATA_I(req_data),
		.TARGET_STRAP_I(tgt_strap), .BUSY_O(busy), .DONE_O(done), .NACK_O(nack), .RDATA_O(rdata));
	scp_dev scp_dev_inst(.CLK_I(clk), .RESET_I(rst), .LINK(link_if.dev),
		.ADDR_STRAP_BIT0_I(dev_strap[0]), .ADDR_STRAP_BIT1_I(dev_strap[1]),
		.ADDR_STRAP_BIT2_I(dev_strap[2]), .STATUS_I(status), .ERROR_I(error),
		.VERSION_I(version), .CMD_BYTE_O(cmd_byte), .CMD_VALID_O(cmd_valid),
		.CMD_FIRST_O(cmd_first), .CMD_I2C_O(cmd_i2c));
	scp_link_monitor scp_link_monitor_inst(.CLK_I(clk), .RESET_I(rst),
		.port_select_n(link_if.port_select_n), .sck(link_if.sck), .so(link_if.so),
		.so_oe(link_if.so_oe), .sda_s_oe(link_if.sda_s_oe), .scl(link_if.scl));

	// Free running system clock
	initial begin
		clk = 1'h0;
		forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
	end

	// Collect bytes away from the launching edge
	always @(negedge clk) begin
		if (cmd_valid === 1'h1) begin
			got_q.push_back({cmd_i2c, cmd_first, cmd_byte});
		end
	end

	// Xorshift step
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Compare and tally
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic give_verdict();
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One host request, waiting for completion
	task automatic xfer(input logic i2c, input logic rd, input logic [1:0] len,
		input logic [23:0] data, input logic [2:0] ts);
		int n;
		got_q.delete();
		@(posedge clk);
		req <= 1'h1;
		req_i2c <= i2c;
		req_read <= rd;
		req_len <= len;
		req_data <= data;
		tgt_strap <= ts;
		@(posedge clk);
		req <= 1'h0;
		n = 0;
		while (done !== 1'h1 && n < 9000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 9000) begin
			fail_count++;
			$display("[ERR] %0t request never completed", $time);
			give_verdict();
		end
		repeat (8) @(negedge clk);
		chk(32'(busy), 32'h0);
	endtask

	// Write and check bytes, flags and address answer
	task automatic wr_check(input logic i2c, input logic [1:0] len, input logic [23:0] data,
		input logic [2:0] ts);
		logic miss;
		miss = i2c && (ts != dev_strap);
		xfer(i2c, 1'h0, len, data, ts);
		chk(32'(nack), 32'(miss));
		chk(32'(got_q.size()), miss ? 32'h0 : 32'(len));
		for (int k = 0; k < got_q.size(); k++) begin
			chk(32'(got_q[k]), 32'({i2c, k == 0, data[23 - 8 * k -: 8]}));
		end
	endtask

	// Read command, disturb sources, then read back
	task automatic rd_check(input logic i2c, input logic [7:0] cmd, input logic [7:0] exp);
		xfer(i2c, 1'h0, 2'h1, {cmd, 16'h0000}, dev_strap);
		seed = xs(seed);
		@(posedge clk);
		status <= seed[7:0];
		error <= seed[15:8];
		version <= seed[23:16];
		xfer(i2c, 1'h1, 2'h1, 24'h000000, dev_strap);
		chk(32'(rdata), 32'(exp));
		chk(32'(got_q.size()), i2c ? 32'h0 : 32'h1);
	endtask

	// Main sequence
	initial begin
		logic [7:0] c, e;
		rst = 1'h1;
		req = 1'h0;
		req_i2c = 1'h0;
		req_read = 1'h0;
		req_len = 2'h1;
		req_data = 24'h000000;
		tgt_strap = 3'h0;
		dev_strap = 3'h5;
		status = 8'h5A;
		error = 8'hC3;
		version = 8'h96;
		seed = 32'h00014585;
		fail_count = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		wr_check(1'h0, 2'h3, 24'hA5C33C, 3'h0);
		wr_check(1'h1, 2'h3, 24'h817EFF, dev_strap);
		wr_check(1'h1, 2'h1, 24'h120000, dev_strap ^ 3'h4);
		// Every strap value, matched and one bit off
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			dev_strap <= 3'(k);
			repeat (4) @(posedge clk);
			wr_check(1'h1, 2'h1, {8'(k), 16'h0000}, 3'(k));
			wr_check(1'h1, 2'h2, 24'hF00F00, 3'(k) ^ 3'h1);
		end
		// All three read commands over both front ends
		for (int m = 0; m < 6; m++) begin
			c = (m % 3 == 0) ? READ_STATUS_CMD_DEF : (m % 3 == 1) ? READ_ERROR_CMD_DEF
				: READ_VERSION_CMD_DEF;
			e = (m % 3 == 0) ? status : (m % 3 == 1) ? error : version;
			rd_check(m >= 3, c, e);
		end
		// Other command leaves the read-back alone
		wr_check(1'h1, 2'h1, 24'h400000, dev_strap);
		xfer(1'h1, 1'h1, 2'h1, 24'h000000, dev_strap);
		chk(32'(rdata), 32'(e));
		for (int r = 0; r < 10; r++) begin
			seed = xs(seed);
			wr_check(seed[0], (seed[2:1] == 2'h0) ? 2'h1 : seed[2:1], seed[31:8],
				seed[3] ? dev_strap : seed[6:4]);
		end
		give_verdict();
	end
endmodule
